// >>> repeater_cfg.svh
// constants for the repeater back-off and acknowledged transmit controller
`ifndef REPEATER_CFG_SVH
`define REPEATER_CFG_SVH
// parameter command codes
`define CMD_DEST_ADDR 8'h00
`define CMD_DELAY_SLOT 8'h19
`define CMD_SRC_ADDR 8'h2A
`define CMD_RF_MODE 8'h3C
// reset values
`define RST_DEST_ADDR 16'h0000
`define RST_DELAY_SLOT 8'h00
`define RST_SRC_ADDR 16'hFFFF
`define RST_RF_MODE 8'h00
// rf mode encodings
`define MODE_REPEATER 8'h03
`define MODE_DEST_ONLY 8'h04
// signal strength arithmetic, in dBm
`define RSSI_REF 16'sh0029
`define RSSI_FLOOR 16'sh0064
`define RSSI_DIV 16'sh000A
// listen window after acking, in slots
`define LISTEN_SLOTS 8'h02
// ack slot length, in slots
`define ACK_SLOTS 8'h01
// serial buffer shape
`define FIFO_WIDTH 8
`define FIFO_DEPTH 16
// random generator seed
`define LFSR_SEED 16'hACE1
`endif

// >>> repeater_pkg.sv
// types for the repeater back-off and acknowledged transmit controller
`default_nettype none
package repeater_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_GATHER = 6'b000010,
    ST_SEND = 6'b000100,
    ST_ACKW = 6'b001000,
    ST_BACKOFF = 6'b010000,
    ST_QUIET = 6'b100000
  } tx_state_t;
  typedef struct packed {
    logic done;
    logic is_ack;
    logic ack_req;
    logic dup;
    logic last;
    logic signed [7:0] rssi;
  } rx_info_t;
  typedef struct packed {
    logic start;
    logic init;
    logic [8:0] len;
  } tx_req_t;
endpackage
`default_nettype wire

// >>> repeater_backoff_ack_tx_control.sv
// repeater back-off, response hold-off and acknowledged transmit sequencing
//
// Functional notes
// - repeat after L times rssi-weighted random slots
// - stronger received signal repeats earlier
// - random term uniform from zero below bound
// - hold serial data at most 15N+1 slots
// - repeat only after whole packet received
// - after ack send next or wait N slots
// - first retry right after ack slot
// - later retries back off 0 to N slots
// - no retry back-off when N is zero
// - back-off never ends during reception
// - after acking hop and listen fixed period
// - ack every copy, forward first only
// - threshold and timeout gate first packet only
// - packet payload at most max packet size
// - check pending data at packet end
// - streaming limit forces 1 to N slots
// - packet counts once toward streaming limit
// - initializer on first packet and retries only
// - sender silent exactly N slots after event
// - receiver quiet random 0 to N-1 slots
`include "repeater_cfg.svh"
`default_nettype none

// ****************************************
// serial input buffer
// ****************************************
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;
  assign in_ready = cnt_reg != (AW+1)'(DEPTH);
  assign out_valid = cnt_reg != '0;
  assign out_data = mem[rd_reg];
  assign count = cnt_reg;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // byte_fifo

// ****************************************
// controller
// ****************************************
module repeater_backoff_ack_tx_control
  import repeater_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // parameter command port
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic [15:0] cmd_rdata,
  output logic cmd_ack,
  // loose configuration
  input wire logic [15:0] slot_len,
  input wire logic [7:0] retry_limit,
  input wire logic [15:0] streaming_limit,
  input wire logic [8:0] max_packet_size,
  input wire logic [8:0] packetization_threshold,
  input wire logic [15:0] packetization_timeout,
  // serial input
  input wire logic ser_valid,
  input wire logic [7:0] ser_data,
  output logic ser_ready,
  // radio receive side
  input wire logic rx_busy,
  input wire rx_info_t rx_info,
  // radio transmit side
  output tx_req_t tx_req,
  output logic [7:0] tx_byte,
  output logic tx_byte_valid,
  input wire logic tx_pull,
  input wire logic tx_done,
  // repeat, ack and forward events
  output logic rpt_start,
  output logic ack_tx,
  output logic hop_req,
  output logic listening,
  output logic fwd_first,
  output logic tx_hold
);
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] to_cyc(input logic [15:0] slots, input logic [15:0] len);
    to_cyc = slots * len;
  endfunction
  function automatic logic [15:0] rand_below(input logic [15:0] r, input logic [15:0] b);
    logic [31:0] p;
    p = r * b;
    rand_below = p[31:16];
  endfunction

  // ****************************************
  // parameter registers
  // ****************************************
  logic [15:0] dest_addr_reg;
  logic [7:0] slot_reg;
  logic [15:0] src_addr_reg;
  logic [7:0] mode_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      dest_addr_reg <= `RST_DEST_ADDR;
      slot_reg <= `RST_DELAY_SLOT;
      src_addr_reg <= `RST_SRC_ADDR;
      mode_reg <= `RST_RF_MODE;
    end else if (cmd_valid && cmd_write) begin
      if (cmd_code == `CMD_DEST_ADDR) begin
        dest_addr_reg <= cmd_wdata;
      end else if (cmd_code == `CMD_DELAY_SLOT) begin
        slot_reg <= cmd_wdata[7:0];
      end else if (cmd_code == `CMD_SRC_ADDR) begin
        src_addr_reg <= cmd_wdata;
      end else if (cmd_code == `CMD_RF_MODE) begin
        mode_reg <= cmd_wdata[7:0];
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_rdata <= '0;
      cmd_ack <= 1'b0;
    end else begin
      cmd_ack <= cmd_valid;
      if (cmd_code == `CMD_DEST_ADDR) begin
        cmd_rdata <= dest_addr_reg;
      end else if (cmd_code == `CMD_DELAY_SLOT) begin
        cmd_rdata <= {8'h00, slot_reg};
      end else if (cmd_code == `CMD_SRC_ADDR) begin
        cmd_rdata <= src_addr_reg;
      end else if (cmd_code == `CMD_RF_MODE) begin
        cmd_rdata <= {8'h00, mode_reg};
      end else begin
        cmd_rdata <= '0;
      end
    end
  end

  // ****************************************
  // random source
  // ****************************************
  logic [15:0] lfsr_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      lfsr_reg <= `LFSR_SEED;
    end else begin
      lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
    end
  end
  logic [15:0] rn;
  assign rn = {8'h00, slot_reg};

  // ****************************************
  // repeat back-off
  // ****************************************
  logic signed [15:0] rssi_term;
  logic [15:0] rpt_slots;
  logic [31:0] rpt_cnt_reg;
  logic rpt_pend_reg;
  logic rpt_load;
  always_comb begin
    rssi_term = '0;
    if (rn != '0) begin
      rssi_term = (-`RSSI_REF - 16'(rx_info.rssi)) / (`RSSI_DIV * $signed(rn));
    end
    if (rssi_term < 0) begin
      rssi_term = '0;
    end
    rpt_slots = 16'(rssi_term) + rand_below(lfsr_reg, rn);
  end
  assign rpt_load = rx_info.done && !rx_info.is_ack && !rx_info.dup && mode_reg == `MODE_REPEATER;
  always_ff @(posedge clk) begin
    if (rst) begin
      rpt_cnt_reg <= '0;
      rpt_pend_reg <= 1'b0;
      rpt_start <= 1'b0;
    end else begin
      rpt_start <= 1'b0;
      if (rpt_load) begin
        rpt_cnt_reg <= to_cyc(rpt_slots, slot_len);
        rpt_pend_reg <= 1'b1;
      end else if (rpt_pend_reg) begin
        if (rpt_cnt_reg != '0) begin
          rpt_cnt_reg <= rpt_cnt_reg - 1'b1;
        end else if (!rx_busy) begin
          rpt_pend_reg <= 1'b0;
          rpt_start <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // response hold-off and receiver quiet
  // ****************************************
  logic [31:0] hold_cnt_reg;
  logic [31:0] hold_max;
  logic [31:0] quiet_rx;
  assign hold_max = to_cyc(16'((`RSSI_REF + `RSSI_FLOOR) / `RSSI_DIV) * rn + rn + 16'h0001, slot_len);
  assign quiet_rx = to_cyc(rand_below(lfsr_reg, rn), slot_len);
  always_ff @(posedge clk) begin
    if (rst) begin
      hold_cnt_reg <= '0;
    end else if (rx_info.done && (mode_reg == `MODE_REPEATER || mode_reg == `MODE_DEST_ONLY)) begin
      hold_cnt_reg <= hold_max;
    end else if (rx_info.done && rx_info.last && rn != '0 && quiet_rx > hold_cnt_reg) begin
      hold_cnt_reg <= quiet_rx;
    end else if (hold_cnt_reg != '0) begin
      hold_cnt_reg <= hold_cnt_reg - 1'b1;
    end
  end
  assign tx_hold = hold_cnt_reg != '0;

  // ****************************************
  // receive acknowledge, hop and forward
  // ****************************************
  logic [31:0] listen_cnt_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_tx <= 1'b0;
      hop_req <= 1'b0;
      fwd_first <= 1'b0;
      listen_cnt_reg <= '0;
    end else begin
      ack_tx <= rx_info.done && rx_info.ack_req;
      hop_req <= rx_info.done && rx_info.ack_req;
      fwd_first <= rx_info.done && !rx_info.is_ack && !rx_info.dup;
      if (rx_info.done && rx_info.ack_req) begin
        listen_cnt_reg <= to_cyc(16'(`LISTEN_SLOTS), slot_len);
      end else if (listen_cnt_reg != '0) begin
        listen_cnt_reg <= listen_cnt_reg - 1'b1;
      end
    end
  end
  assign listening = listen_cnt_reg != '0;

  // ****************************************
  // serial buffer
  // ****************************************
  logic fifo_valid;
  logic fifo_pop;
  logic [$clog2(`FIFO_DEPTH):0] fifo_count;
  byte_fifo #(.WIDTH(`FIFO_WIDTH), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(ser_valid),
    .in_data(ser_data),
    .in_ready(ser_ready),
    .out_valid(fifo_valid),
    .out_data(tx_byte),
    .out_ready(fifo_pop),
    .count(fifo_count)
  );

  // ****************************************
  // transmit sequencer
  // ****************************************
  tx_state_t state_reg;
  logic [31:0] wait_reg;
  logic [15:0] gto_reg;
  logic [8:0] len_reg;
  logic [8:0] sent_reg;
  logic [7:0] retry_reg;
  logic [15:0] evt_bytes_reg;
  logic retx_reg;
  logic bo_send_reg;
  logic ack_mode;
  logic lim_hit;
  logic more;
  logic [8:0] avail;
  logic [31:0] lim_wait;
  assign ack_mode = retry_limit != 8'h00;
  assign lim_hit = evt_bytes_reg >= streaming_limit;
  assign more = fifo_count != '0;
  assign avail = 9'(fifo_count) > max_packet_size ? max_packet_size : 9'(fifo_count);
  assign lim_wait = to_cyc(rn == '0 ? 16'h0001 : 16'h0001 + rand_below(lfsr_reg, rn), slot_len);
  assign tx_byte_valid = fifo_valid && state_reg == ST_SEND && !retx_reg && sent_reg != len_reg;
  assign fifo_pop = tx_byte_valid && tx_pull;
  always_ff @(posedge clk) begin
    if (rst) begin
      sent_reg <= '0;
    end else if (tx_req.start) begin
      sent_reg <= fifo_pop ? 9'h001 : 9'h000; // a pull on the start cycle is the new packet's
    end else if (fifo_pop) begin
      sent_reg <= sent_reg + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      wait_reg <= '0;
      gto_reg <= '0;
      len_reg <= '0;
      retry_reg <= '0;
      evt_bytes_reg <= '0;
      retx_reg <= 1'b0;
      bo_send_reg <= 1'b0;
      tx_req <= '0;
    end else begin
      tx_req.start <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          gto_reg <= '0;
          evt_bytes_reg <= '0;
          if (more && !tx_hold && !rx_busy) begin
            state_reg <= ST_GATHER;
          end
        end
        ST_GATHER: begin
          gto_reg <= gto_reg + 1'b1;
          if (9'(fifo_count) >= packetization_threshold || gto_reg >= packetization_timeout
              || fifo_count == 5'(`FIFO_DEPTH)) begin
            state_reg <= ST_SEND;
            len_reg <= avail;
            evt_bytes_reg <= 16'(avail);
            retry_reg <= '0;
            retx_reg <= 1'b0;
            tx_req <= '{start: 1'b1, init: 1'b1, len: avail};
          end
        end
        ST_SEND: begin
          if (tx_done) begin
            if (ack_mode) begin
              state_reg <= ST_ACKW;
              wait_reg <= to_cyc(16'(`ACK_SLOTS), slot_len);
            end else if (lim_hit) begin
              state_reg <= ST_BACKOFF;
              bo_send_reg <= 1'b0;
              wait_reg <= lim_wait;
            end else if (!more) begin
              state_reg <= ST_QUIET;
              wait_reg <= to_cyc(rn, slot_len);
            end else begin
              len_reg <= avail;
              evt_bytes_reg <= evt_bytes_reg + 16'(avail);
              retx_reg <= 1'b0;
              tx_req <= '{start: 1'b1, init: 1'b0, len: avail};
            end
          end
        end
        ST_ACKW: begin
          if (wait_reg != '0) begin
            wait_reg <= wait_reg - 1'b1;
          end
          if ((rx_info.done && rx_info.is_ack) || (wait_reg == '0 && retry_reg >= retry_limit)) begin
            if (lim_hit) begin
              state_reg <= ST_BACKOFF;
              bo_send_reg <= 1'b0;
              wait_reg <= lim_wait;
            end else if (more) begin
              state_reg <= ST_SEND;
              len_reg <= avail;
              evt_bytes_reg <= evt_bytes_reg + 16'(avail);
              retry_reg <= '0;
              retx_reg <= 1'b0;
              tx_req <= '{start: 1'b1, init: 1'b0, len: avail};
            end else begin
              state_reg <= ST_QUIET;
              wait_reg <= to_cyc(rn, slot_len);
            end
          end else if (wait_reg == '0) begin
            retry_reg <= retry_reg + 1'b1;
            retx_reg <= 1'b1;
            if (retry_reg == '0 || rn == '0) begin
              state_reg <= ST_SEND;
              tx_req <= '{start: 1'b1, init: 1'b1, len: len_reg};
            end else begin
              state_reg <= ST_BACKOFF;
              bo_send_reg <= 1'b1;
              wait_reg <= to_cyc(rand_below(lfsr_reg, rn + 16'h0001), slot_len);
            end
          end
        end
        ST_BACKOFF: begin
          if (wait_reg != '0) begin
            wait_reg <= wait_reg - 1'b1;
          end else if (!rx_busy) begin
            if (bo_send_reg) begin
              state_reg <= ST_SEND;
              tx_req <= '{start: 1'b1, init: 1'b1, len: len_reg};
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_QUIET: begin
          if (wait_reg != '0) begin
            wait_reg <= wait_reg - 1'b1;
          end else begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_pkt_len;
    @(posedge clk) disable iff (rst) tx_req.start |-> tx_req.len <= max_packet_size;
  endproperty
  a_pkt_len: assert property (p_pkt_len) else $error("packet longer than max size");
  property p_first_retry;
    @(posedge clk) disable iff (rst)
      state_reg == ST_ACKW && wait_reg == '0 && !(rx_info.done && rx_info.is_ack) && retry_reg == '0
      && retry_limit != '0 |=> tx_req.start && tx_req.init && state_reg == ST_SEND;
  endproperty
  a_first_retry: assert property (p_first_retry) else $error("first retry delayed");
  property p_retx_init;
    @(posedge clk) disable iff (rst) tx_req.start && retx_reg |-> tx_req.init;
  endproperty
  a_retx_init: assert property (p_retx_init) else $error("retry without initializer");
  property p_no_tx_rx;
    @(posedge clk) disable iff (rst) state_reg == ST_BACKOFF && rx_busy |=> state_reg != ST_SEND;
  endproperty
  a_no_tx_rx: assert property (p_no_tx_rx) else $error("resumed during reception");
  property p_rpt_rx;
    @(posedge clk) disable iff (rst) rpt_start |-> $past(rpt_pend_reg) && !$past(rx_busy);
  endproperty
  a_rpt_rx: assert property (p_rpt_rx) else $error("repeat without stored packet");
  property p_ack_copy;
    @(posedge clk) disable iff (rst) rx_info.done && rx_info.ack_req |=> ack_tx && hop_req ##1 listening;
  endproperty
  a_ack_copy: assert property (p_ack_copy) else $error("copy not acknowledged");
  property p_dup_fwd;
    @(posedge clk) disable iff (rst) rx_info.done && rx_info.dup |=> !fwd_first;
  endproperty
  a_dup_fwd: assert property (p_dup_fwd) else $error("duplicate forwarded");
  property p_quiet_len;
    @(posedge clk) disable iff (rst)
      $changed(state_reg) && state_reg == ST_QUIET |-> wait_reg == to_cyc(rn, slot_len);
  endproperty
  a_quiet_len: assert property (p_quiet_len) else $error("quiet length wrong");
  property p_hold_max;
    @(posedge clk) disable iff (rst) hold_cnt_reg > $past(hold_cnt_reg) |-> hold_cnt_reg <= hold_max;
  endproperty
  a_hold_max: assert property (p_hold_max) else $error("hold beyond maximum");
endmodule // repeater_backoff_ack_tx_control
`default_nettype wire

// >>> radio_peer_model.sv
// peer radio model: pulls packet bytes, ends packets, acks, sends packets
`default_nettype none
module radio_peer_model
  import repeater_pkg::*;
(
  // clock
  input wire logic clk,
  // transmit side
  input wire tx_req_t tx_req,
  input wire logic tx_byte_valid,
  output logic tx_pull,
  output logic tx_done,
  // receive side
  output logic rx_busy,
  output rx_info_t rx_info,
  // behaviour controls
  input wire logic ack_on,
  input wire logic [3:0] drop_n,
  input wire logic [3:0] pull_gap,
  input wire logic hold_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  int pulled = 0;
  int drops = 0;
  int n, t;
  logic retry = 1'b0;
  logic busy_self = 1'b0;
  assign rx_busy = hold_busy | busy_self;
  // ****************************************
  // transmit side
  // ****************************************
  initial begin
    tx_pull = 1'b0;
    tx_done = 1'b0;
    rx_info = '0;
    forever begin
      if (tx_req.start === 1'b1) begin
        // a resent copy is held by the radio, nothing is pulled
        n = retry ? 0 : int'(tx_req.len);
        repeat (pull_gap) @(negedge clk);
        for (t = 0; t < 64 && n > 0; t++) begin
          tx_pull = tx_byte_valid;
          @(negedge clk);
          if (tx_pull) begin
            n--;
            pulled++;
          end
        end
        tx_pull = 1'b0;
        tx_done = 1'b1;
        @(negedge clk);
        tx_done = 1'b0;
        retry = ack_on && drops < int'(drop_n);
        drops = retry ? drops + 1 : 0;
        if (ack_on && !retry) begin
          rx_info = '{done: 1'b1, is_ack: 1'b1, default: '0};
          @(negedge clk);
          rx_info = '0;
        end
      end else begin
        @(negedge clk);
      end
    end
  end
  // sends one whole packet toward the device
  task automatic send_pkt(input logic signed [7:0] rssi, input logic ack_req, input logic dup);
    busy_self = 1'b1;
    repeat (3) @(negedge clk);
    busy_self = 1'b0;
    rx_info = '{done: 1'b1, is_ack: 1'b0, ack_req: ack_req, dup: dup, last: 1'b0, rssi: rssi};
    @(negedge clk);
    rx_info = '0;
  endtask
endmodule // radio_peer_model
`default_nettype wire

// >>> tb.sv
// self-checking testbench for the repeater transmit controller
`default_nettype none
module tb
  import repeater_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // signals and instances
  // ****************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic [7:0] cmd_code = 8'h00;
  logic [15:0] cmd_wdata = 16'h0000;
  logic [15:0] cmd_rdata, rd;
  logic [15:0] slot_len = 16'h0004;
  logic [7:0] retry_limit = 8'h00;
  logic [15:0] streaming_limit = 16'h0008;
  logic [8:0] max_packet_size = 9'h004;
  logic [8:0] packetization_threshold = 9'h004;
  logic [15:0] packetization_timeout = 16'h00C8;
  logic ser_valid = 1'b0;
  logic [7:0] ser_data = 8'h00;
  logic cmd_ack, ser_ready, rx_busy, tx_byte_valid, tx_pull, tx_done;
  logic rpt_start, ack_tx, hop_req, listening, fwd_first, tx_hold;
  logic [7:0] tx_byte;
  rx_info_t rx_info;
  tx_req_t tx_req;
  logic ack_on = 1'b0;
  logic hold_busy = 1'b0;
  logic [3:0] drop_n = 4'h0;
  logic [3:0] pull_gap = 4'h0;
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0, n_start = 0, n_rpt = 0, n_ack = 0, n_hop = 0, n_fwd = 0, n_lsn = 0;
  int done_cyc = 0, ack_cyc = 0, rx_cyc = 0, rpt_cyc = 0, hold_len = 0, hold_max = 0;
  int push_seq = 0, pop_seq = 0;
  int gap_log [16];
  logic init_log [16];
  logic [8:0] len_log [16];
  logic [7:0] codes [5] = '{8'h00, 8'h19, 8'h2A, 8'h3C, 8'h55};
  logic [15:0] rst_v [5] = '{16'h0000, 16'h0000, 16'hFFFF, 16'h0000, 16'h0000};
  logic [15:0] wr_v [5] = '{16'hA5A5, 16'h0102, 16'h1234, 16'h0100, 16'hBEEF};
  logic [15:0] rb_v [5] = '{16'hA5A5, 16'h0002, 16'h1234, 16'h0000, 16'h0000};
  always #10 clk = ~clk;
  repeater_backoff_ack_tx_control dut (
    .clk, .rst, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata, .cmd_rdata, .cmd_ack,
    .slot_len, .retry_limit, .streaming_limit, .max_packet_size, .packetization_threshold,
    .packetization_timeout, .ser_valid, .ser_data, .ser_ready, .rx_busy, .rx_info, .tx_req,
    .tx_byte, .tx_byte_valid, .tx_pull, .tx_done, .rpt_start, .ack_tx, .hop_req, .listening,
    .fwd_first, .tx_hold
  );
  radio_peer_model peer (
    .clk, .tx_req, .tx_byte_valid, .tx_pull, .tx_done, .rx_busy, .rx_info, .ack_on, .drop_n,
    .pull_gap, .hold_busy
  );
  // ****************************************
  // monitor and tasks
  // ****************************************
  always @(posedge clk) begin
    cyc++;
    if (tx_req.start === 1'b1) begin
      init_log[n_start % 16] = tx_req.init;
      len_log[n_start % 16] = tx_req.len;
      gap_log[n_start % 16] = cyc - done_cyc;
      n_start++;
    end
    if (tx_done) done_cyc = cyc;
    if (rx_info.done && rx_info.is_ack) ack_cyc = cyc;
    if (rx_info.done && !rx_info.is_ack) rx_cyc = cyc;
    if (rpt_start === 1'b1) begin
      n_rpt++;
      rpt_cyc = cyc;
    end
    if (ack_tx === 1'b1) n_ack++;
    if (hop_req === 1'b1) n_hop++;
    if (fwd_first === 1'b1) n_fwd++;
    if (listening === 1'b1) n_lsn++;
    hold_len = (rx_info.done === 1'b1 || tx_hold !== 1'b1) ? 0 : hold_len + 1;
    if (hold_len > hold_max) hold_max = hold_len;
    if (tx_byte_valid === 1'b1 && tx_pull) begin
      chk("tx_byte", 16'(pop_seq % 256), {8'h00, tx_byte});
      pop_seq++;
    end
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_time(input string what, input int lo, input int hi, input int got);
    total_checks++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0d to %0d seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic cmd(input logic wr, input logic [7:0] code, input logic [15:0] wdata);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_code = code;
    cmd_wdata = wdata;
    @(negedge clk);
    chk("cmd_ack", 16'h0001, {15'h0000, cmd_ack});
    rd = cmd_rdata;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    @(negedge clk);
  endtask
  task automatic push(input int n);
    for (int i = 0; i < n; i++) begin
      ser_data = 8'(push_seq % 256);
      ser_valid = 1'b1;
      for (int t = 0; t < 400 && ser_ready !== 1'b1; t++) @(negedge clk);
      @(negedge clk);
      push_seq++;
    end
    ser_valid = 1'b0;
  endtask
  task automatic wait_starts(input int k);
    for (int t = 0; t < 800 && n_start < k; t++) @(negedge clk);
  endtask
  task automatic wait_ack();
    for (int t = 0; t < 400 && ack_cyc <= done_cyc; t++) @(negedge clk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    chk("ser_ready", 16'h0001, {15'h0000, ser_ready});
    for (int i = 0; i < 5; i++) begin
      cmd(1'b0, codes[i], 16'h0000);
      chk("reset value", rst_v[i], rd);
      cmd(1'b1, codes[i], wr_v[i]);
      cmd(1'b0, codes[i], 16'h0000);
      chk("readback", rb_v[i], rd);
    end
    // streaming: two packets, limit reached, then a new event
    push(12);
    wait_starts(3);
    chk("len0", 16'h0004, {7'h00, len_log[0]});
    chk("init0", 16'h0001, {15'h0000, init_log[0]});
    chk("init1", 16'h0000, {15'h0000, init_log[1]});
    chk_time("limit back-off", 8, 12, gap_log[2]);
    chk("init2", 16'h0001, {15'h0000, init_log[2]});
    // acknowledged mode, one lost ack then two lost acks
    repeat (20) @(negedge clk);
    retry_limit = 8'h02;
    streaming_limit = 16'h0064;
    ack_on = 1'b1;
    drop_n = 4'h1;
    push(4);
    wait_starts(5);
    wait_ack();
    chk_time("first retry", 4, 7, gap_log[4]);
    chk("retry init", 16'h0001, {15'h0000, init_log[4]});
    drop_n = 4'h2;
    push(4);
    wait_starts(6);
    chk_time("quiet after ack", 8, 40, cyc - ack_cyc);
    wait_starts(8);
    wait_ack();
    chk_time("retry one", 4, 7, gap_log[6]);
    chk_time("retry two", 4, 15, gap_log[7]);
    chk("retry two init", 16'h0001, {15'h0000, init_log[7]});
    chk("pulled once", 16'(push_seq), 16'(peer.pulled));
    // repeater: rssi weighted back-off, acks, forwarding, hold-off
    ack_on = 1'b0;
    retry_limit = 8'h00;
    cmd(1'b1, 8'h3C, 16'h0003);
    cmd(1'b1, 8'h19, 16'h0001);
    peer.send_pkt(-8'sd91, 1'b1, 1'b0);
    repeat (40) @(negedge clk);
    chk_time("weak repeat", 20, 23, rpt_cyc - rx_cyc);
    peer.send_pkt(-8'sd51, 1'b1, 1'b0);
    repeat (40) @(negedge clk);
    chk_time("strong repeat", 4, 7, rpt_cyc - rx_cyc);
    peer.send_pkt(-8'sd30, 1'b0, 1'b0);
    repeat (40) @(negedge clk);
    chk_time("clamped repeat", 0, 3, rpt_cyc - rx_cyc);
    peer.send_pkt(-8'sd51, 1'b1, 1'b1);
    repeat (80) @(negedge clk);
    chk("repeats", 16'h0003, 16'(n_rpt));
    chk("acks", 16'h0003, 16'(n_ack));
    chk("forwards", 16'h0003, 16'(n_fwd));
    chk("hops", 16'h0003, 16'(n_hop));
    chk_time("listen", 8, 24, n_lsn);
    chk_time("hold-off", 1, 64, hold_max);
    cmd(1'b1, 8'h3C, 16'h0004);
    peer.send_pkt(-8'sd51, 1'b0, 1'b0);
    repeat (80) @(negedge clk);
    chk("destination repeats", 16'h0003, 16'(n_rpt));
    // buffer fill while receiving, then drain with a slow radio and a busy back-off
    hold_busy = 1'b1;
    push(16);
    chk("full", 16'h0000, {15'h0000, ser_ready});
    pull_gap = 4'h3;
    streaming_limit = 16'h0008;
    hold_busy = 1'b0;
    wait_starts(10);
    @(posedge tx_done);
    @(negedge clk);
    hold_busy = 1'b1;
    repeat (10) @(negedge clk);
    hold_busy = 1'b0;
    wait_starts(12);
    chk_time("busy back-off", 12, 16, gap_log[10]);
    for (int t = 0; t < 400 && pop_seq != push_seq; t++) @(negedge clk);
    chk("drained", 16'(push_seq), 16'(pop_seq));
    chk("ser_ready", 16'h0001, {15'h0000, ser_ready});
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
